/* verilog/bfie_core.sv */
// Executor for bit, rotate, flag, sleep and watchdog instructions.
// Assumes an APB master on the same clock; memory for pointer moves is modelled
// as a small local array.
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module bfie_core (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic wake_i,
  output logic sleep_req_o,
  output logic wdog_restart_o,
  output logic busy_o
);

  // ==========================================================================
  // State
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01
  } bfie_state_t;

  bfie_state_t state;
  logic [1:0] cyc_left;
  logic [3:0] op;
  logic [2:0] bit_sel;
  logic [1:0] reg_sel;
  logic [7:0] status;
  logic [7:0] wreg [4];
  logic [7:0] ioreg;
  logic [7:0] ptr;
  logic [7:0] dmem [16];
  logic [15:0] sleep_count;
  logic [15:0] wdog_count;
  logic [7:0] rot_res;
  logic [7:0] rot_stat;
  logic apb_wr;
  logic apb_rd;
  logic cmd_take;
  logic last_cyc;

  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign apb_rd = psel_i && penable_i && !pwrite_i;
  assign cmd_take = apb_wr && (paddr_i == bfie_pkg::OFF_COMMAND) && (state == ST_IDLE);
  assign last_cyc = (state == ST_EXEC) && (cyc_left == bfie_pkg::CYC_ONE);

  bfie_alu u_alu (
    .operand_i(wreg[reg_sel]),
    .status_i(status),
    .left_i(op == bfie_pkg::OP_ROTATE_LEFT_CARRY),
    .result_o(rot_res),
    .status_o(rot_stat)
  );

  // ==========================================================================
  // Sequencer: takes a command, counts its cycles
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cyc_left <= 2'h0;
      op <= 4'h0;
      bit_sel <= 3'h0;
      reg_sel <= 2'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (cmd_take) begin
            op <= pwdata_i[bfie_pkg::CMD_OP_LSB +: 4];
            bit_sel <= pwdata_i[bfie_pkg::CMD_BIT_LSB +: 3];
            reg_sel <= pwdata_i[bfie_pkg::CMD_REG_LSB +: 2];
            cyc_left <= bfie_pkg::op_cycles(pwdata_i[bfie_pkg::CMD_OP_LSB +: 4]);
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          cyc_left <= cyc_left - 2'h1;
          if (last_cyc) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Status flags: loaded by an APB write while idle, else changed only on the last cycle of the owning instruction
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      status <= bfie_pkg::STATUS_RESET;
    end else if (apb_wr && paddr_i == bfie_pkg::OFF_STATUS && state == ST_IDLE) begin
      status <= pwdata_i[7:0];
    end else if (last_cyc) begin
      case (op)
        bfie_pkg::OP_ROTATE_LEFT_CARRY, bfie_pkg::OP_ROTATE_RIGHT_CARRY:
          status <= rot_stat;
        bfie_pkg::OP_BIT_TO_TRANSFER_FLAG:
          status[bfie_pkg::FLAG_T] <= wreg[reg_sel][bit_sel];
        bfie_pkg::OP_SET_OVERFLOW_FLAG: status[bfie_pkg::FLAG_V] <= 1'b1;
        bfie_pkg::OP_CLEAR_OVERFLOW_FLAG: status[bfie_pkg::FLAG_V] <= 1'b0;
        bfie_pkg::OP_SET_HALF_CARRY_FLAG: status[bfie_pkg::FLAG_H] <= 1'b1;
        bfie_pkg::OP_CLEAR_HALF_CARRY_FLAG: status[bfie_pkg::FLAG_H] <= 1'b0;
        bfie_pkg::OP_SET_SIGN_FLAG: status[bfie_pkg::FLAG_S] <= 1'b1;
        bfie_pkg::OP_CLEAR_SIGN_FLAG: status[bfie_pkg::FLAG_S] <= 1'b0;
        default: status <= status;
      endcase
    end
  end

  // ==========================================================================
  // Working registers: rotate result, bit load, pointer load into the selected register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        wreg[i] <= bfie_pkg::REG_RESET;
      end
    end else if (apb_wr && paddr_i == bfie_pkg::OFF_WREG && state == ST_IDLE) begin
      wreg[pwdata_i[9:8]] <= pwdata_i[7:0];
    end else if (last_cyc) begin
      case (op)
        bfie_pkg::OP_ROTATE_LEFT_CARRY, bfie_pkg::OP_ROTATE_RIGHT_CARRY:
          wreg[reg_sel] <= rot_res;
        bfie_pkg::OP_TRANSFER_FLAG_TO_BIT:
          wreg[reg_sel][bit_sel] <= status[bfie_pkg::FLAG_T];
        bfie_pkg::OP_PTR_TRANSFER:
          if (bit_sel[0] == 1'b0) begin
            wreg[reg_sel] <= dmem[ptr[3:0]];
          end
        default: wreg[reg_sel] <= wreg[reg_sel];
      endcase
    end
  end

  // ==========================================================================
  // I/O register and pointer register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ioreg <= bfie_pkg::REG_RESET;
      ptr <= bfie_pkg::REG_RESET;
    end else if (apb_wr && state == ST_IDLE && paddr_i == bfie_pkg::OFF_IOREG) begin
      ioreg <= pwdata_i[7:0];
    end else if (apb_wr && state == ST_IDLE && paddr_i == bfie_pkg::OFF_PTR) begin
      ptr <= pwdata_i[7:0];
    end else if (last_cyc && op == bfie_pkg::OP_IO_BIT_SET) begin
      ioreg[bit_sel] <= 1'b1;
    end else if (last_cyc && op == bfie_pkg::OP_IO_BIT_CLEAR) begin
      ioreg[bit_sel] <= 1'b0;
    end
  end

  // Store through pointer; no reset needed for memory contents
  always_ff @(posedge clock_i) begin
    if (last_cyc && op == bfie_pkg::OP_PTR_TRANSFER && bit_sel[0]) begin
      dmem[ptr[3:0]] <= wreg[reg_sel];
    end
  end

  // ==========================================================================
  // Sleep request held until wake; watchdog restart pulse
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sleep_req_o <= 1'b0;
      wdog_restart_o <= 1'b0;
      sleep_count <= 16'h0000;
      wdog_count <= 16'h0000;
    end else begin
      wdog_restart_o <= last_cyc && op == bfie_pkg::OP_WATCHDOG_RESTART;
      if (last_cyc && op == bfie_pkg::OP_SLEEP) begin
        sleep_req_o <= 1'b1;
        sleep_count <= sleep_count + 16'h0001;
      end else if (wake_i) begin
        sleep_req_o <= 1'b0;
      end
      if (last_cyc && op == bfie_pkg::OP_WATCHDOG_RESTART) begin
        wdog_count <= wdog_count + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // APB slave: zero wait states, error on unmapped address
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state == ST_EXEC) ? !last_cyc : cmd_take;
      pready_o <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      if (psel_i && !penable_i) begin
        prdata_o <= 32'h0000_0000;
        case (paddr_i)
          bfie_pkg::OFF_COMMAND: prdata_o <= {16'h0000, 2'h0, reg_sel, 1'b0, bit_sel, 4'h0, op};
          bfie_pkg::OFF_STATUS: prdata_o <= {24'h00_0000, status};
          bfie_pkg::OFF_STATE: prdata_o <= {28'h000_0000, cyc_left, sleep_req_o, busy_o};
          bfie_pkg::OFF_WREG: prdata_o <= {wreg[3], wreg[2], wreg[1], wreg[0]};
          bfie_pkg::OFF_IOREG: prdata_o <= {24'h00_0000, ioreg};
          bfie_pkg::OFF_PTR: prdata_o <= {24'h00_0000, ptr};
          bfie_pkg::OFF_EVENTS: prdata_o <= {wdog_count, sleep_count};
          default: pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================================================
  // Assertions
  // Status bit that an instruction may touch outside the rotates; all others hold
  function automatic logic [7:0] owned_flag(input logic [3:0] code);
    owned_flag = 8'h00;
    case (code)
      bfie_pkg::OP_BIT_TO_TRANSFER_FLAG: owned_flag[bfie_pkg::FLAG_T] = 1'b1;
      bfie_pkg::OP_SET_OVERFLOW_FLAG, bfie_pkg::OP_CLEAR_OVERFLOW_FLAG:
        owned_flag[bfie_pkg::FLAG_V] = 1'b1;
      bfie_pkg::OP_SET_HALF_CARRY_FLAG, bfie_pkg::OP_CLEAR_HALF_CARRY_FLAG:
        owned_flag[bfie_pkg::FLAG_H] = 1'b1;
      bfie_pkg::OP_SET_SIGN_FLAG, bfie_pkg::OP_CLEAR_SIGN_FLAG:
        owned_flag[bfie_pkg::FLAG_S] = 1'b1;
      default: owned_flag = 8'h00;
    endcase
  endfunction

  // Two-cycle ops land on the edge that ends their second execute cycle,
  // so the new value is first seen three edges after the take edge
  a_ioset_two_cycles: assert property (@(posedge clock_i) disable iff (rst_i)
    cmd_take && pwdata_i[3:0] == 4'b0001 |-> ##3 ioreg[bit_sel] && $stable(status))
    else $error("io bit set wrong");
  a_ioclr_two_cycles: assert property (@(posedge clock_i) disable iff (rst_i)
    cmd_take && pwdata_i[3:0] == 4'b0010 |-> ##3 !ioreg[bit_sel] && $stable(status))
    else $error("io bit clear wrong");
  a_rotl_carry: assert property (@(posedge clock_i) disable iff (rst_i)
    last_cyc && op == 4'b0011 |=> status[0] == $past(wreg[reg_sel][7]))
    else $error("rotate left carry wrong");
  a_rotr_carry: assert property (@(posedge clock_i) disable iff (rst_i)
    last_cyc && op == 4'b0100 |=> wreg[reg_sel][7] == $past(status[0]))
    else $error("rotate right wrong");
  a_tflag_copy: assert property (@(posedge clock_i) disable iff (rst_i)
    last_cyc && op == 4'b0101 |=> status[6] == $past(wreg[reg_sel][bit_sel]))
    else $error("bit to T wrong");
  a_tflag_load: assert property (@(posedge clock_i) disable iff (rst_i)
    last_cyc && op == 4'b0110 |=> $stable(status))
    else $error("bit load changed flags");
  a_ovf_set: assert property (@(posedge clock_i) disable iff (rst_i)
    last_cyc && op == 4'b0111 |=> status[3])
    else $error("overflow set wrong");
  a_ovf_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    last_cyc && op == 4'b1000 |=> !status[3])
    else $error("overflow clear wrong");
  a_half_set: assert property (@(posedge clock_i) disable iff (rst_i)
    last_cyc && op == 4'b1001 |=> status[5])
    else $error("half carry set wrong");
  a_half_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    last_cyc && op == 4'b1010 |=> !status[5])
    else $error("half carry clear wrong");
  a_sign_set: assert property (@(posedge clock_i) disable iff (rst_i)
    last_cyc && op == 4'b1011 |=> status[4])
    else $error("sign set wrong");
  a_sign_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    last_cyc && op == 4'b1100 |=> !status[4])
    else $error("sign clear wrong");
  a_flag_others: assert property (@(posedge clock_i) disable iff (rst_i)
    last_cyc && op != 4'b0011 && op != 4'b0100 |=>
    ((status ^ $past(status)) & ~owned_flag($past(op))) == 8'h00)
    else $error("unowned status bit changed");
  a_sleep_issue: assert property (@(posedge clock_i) disable iff (rst_i)
    cmd_take && pwdata_i[3:0] == 4'b1101 |-> ##2 sleep_req_o)
    else $error("sleep not requested");
  a_wdog_pulse: assert property (@(posedge clock_i) disable iff (rst_i)
    cmd_take && pwdata_i[3:0] == 4'b1110 |-> ##2 wdog_restart_o ##1 !wdog_restart_o)
    else $error("watchdog pulse wrong");
  a_ptr_two: assert property (@(posedge clock_i) disable iff (rst_i)
    cmd_take && pwdata_i[3:0] == 4'b1111 |=> state == ST_EXEC ##1 state == ST_EXEC ##1
    state == ST_IDLE)
    else $error("pointer move length wrong");
  a_sleep_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    sleep_req_o && !wake_i |=> sleep_req_o)
    else $error("sleep request dropped");

  // Bus handshake: ready stands in every access phase, for one cycle only
  a_access_ready: assert property (@(posedge clock_i) disable iff (rst_i)
    apb_wr || apb_rd |-> pready_o)
    else $error("access phase without ready");
  a_ready_single: assert property (@(posedge clock_i) disable iff (rst_i)
    pready_o |=> !pready_o)
    else $error("ready held too long");

endmodule

/* verilog/bfie_pkg.sv */
// Package for the bit and flag instruction executor.
// Assumes one 25 MHz clock and a synchronous active-high reset.
package bfie_pkg;

  // ==========================================================================
  // Status register bit positions
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ==========================================================================
  // Cycle counts per instruction
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // ==========================================================================
  // APB register map: byte offsets
  localparam logic [7:0] OFF_COMMAND = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_STATE = 8'h08;
  localparam logic [7:0] OFF_WREG = 8'h0C;
  localparam logic [7:0] OFF_IOREG = 8'h10;
  localparam logic [7:0] OFF_PTR = 8'h14;
  localparam logic [7:0] OFF_EVENTS = 8'h18;

  // Command register field positions
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_BIT_LSB = 8;
  localparam int unsigned CMD_REG_LSB = 12;

  // ==========================================================================
  // Operation codes
  typedef enum logic [3:0] {
    OP_NOP = 4'b0000,
    OP_IO_BIT_SET = 4'b0001,
    OP_IO_BIT_CLEAR = 4'b0010,
    OP_ROTATE_LEFT_CARRY = 4'b0011,
    OP_ROTATE_RIGHT_CARRY = 4'b0100,
    OP_BIT_TO_TRANSFER_FLAG = 4'b0101,
    OP_TRANSFER_FLAG_TO_BIT = 4'b0110,
    OP_SET_OVERFLOW_FLAG = 4'b0111,
    OP_CLEAR_OVERFLOW_FLAG = 4'b1000,
    OP_SET_HALF_CARRY_FLAG = 4'b1001,
    OP_CLEAR_HALF_CARRY_FLAG = 4'b1010,
    OP_SET_SIGN_FLAG = 4'b1011,
    OP_CLEAR_SIGN_FLAG = 4'b1100,
    OP_SLEEP = 4'b1101,
    OP_WATCHDOG_RESTART = 4'b1110,
    OP_PTR_TRANSFER = 4'b1111
  } bfie_op_t;

  // Execution length of each operation
  function automatic logic [1:0] op_cycles(input logic [3:0] op);
    case (op)
      OP_IO_BIT_SET, OP_IO_BIT_CLEAR, OP_PTR_TRANSFER: op_cycles = CYC_TWO;
      default: op_cycles = CYC_ONE;
    endcase
  endfunction

endpackage

/* verilog/bfie_alu.sv */
// Combinational rotate and flag unit for the executor.
// Assumes the caller holds operands stable for the cycle it samples.
`timescale 1ns/1ps
module bfie_alu (
  input wire logic [7:0] operand_i,
  input wire logic [7:0] status_i,
  input wire logic left_i,
  output logic [7:0] result_o,
  output logic [7:0] status_o
);

  // ==========================================================================
  // Rotate through carry and flag update
  always_comb begin
    status_o = status_i;
    if (left_i) begin
      result_o = {operand_i[6:0], status_i[bfie_pkg::FLAG_C]};
      status_o[bfie_pkg::FLAG_C] = operand_i[7];
    end else begin
      result_o = {status_i[bfie_pkg::FLAG_C], operand_i[7:1]};
      status_o[bfie_pkg::FLAG_C] = operand_i[0];
    end
    status_o[bfie_pkg::FLAG_Z] = (result_o == 8'h00);
    status_o[bfie_pkg::FLAG_N] = result_o[7];
    status_o[bfie_pkg::FLAG_V] = result_o[7] ^ status_o[bfie_pkg::FLAG_C];
    status_o[bfie_pkg::FLAG_S] = status_o[bfie_pkg::FLAG_N] ^ status_o[bfie_pkg::FLAG_V];
  end

endmodule

/* dv/tb.sv */
// Self-checking bench for the bit and flag instruction executor.
// Assumes the executor's APB map, command field packing and zero-wait bus timing.
`timescale 1ns/1ps
module tb;
  // ==========================================================================
  // Signals
  logic clock_i = 1'h0;
  logic rst_i = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic wake = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, sleep_req, wdog, busy, err;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  int nbusy, npulse;

  bfie_core dut_u (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .wake_i(wake), .sleep_req_o(sleep_req),
    .wdog_restart_o(wdog), .busy_o(busy));

  // ==========================================================================
  // Clock and hang guard
  initial begin
    forever #20 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      $display("BAD %0t run took too long", $time);
      conclude();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock_i);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'h1;
    @(posedge clock_i);
    while (pready !== 1'h1 && k < 50) begin
      k++;
      @(posedge clock_i);
    end
    if (k == 50) chk(32'h0000_0000, 32'h0000_0001, "no ready");
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic setreg(input logic [1:0] i, input logic [7:0] v);
    wr(bfie_pkg::OFF_WREG, {22'h00_0000, i, v});
  endtask

  // Issue a command, then count busy and restart-pulse cycles
  task automatic exec(input logic [3:0] op, input logic [2:0] b, input logic [1:0] r);
    wr(bfie_pkg::OFF_COMMAND, {18'h0_0000, r, 1'h0, b, 4'h0, op});
    nbusy = 0;
    npulse = 0;
    repeat (8) begin
      #1;
      nbusy += int'(busy === 1'h1);
      npulse += int'(wdog === 1'h1);
      @(posedge clock_i);
    end
  endtask

  task automatic chk_reg(input logic [1:0] i, input logic [7:0] v, input string what);
    apb(1'h0, bfie_pkg::OFF_WREG, 32'h0000_0000);
    chk(rd[8*i +: 8], v, what);
  endtask

  task automatic chk_st(input logic [7:0] m, input logic [7:0] v, input string what);
    apb(1'h0, bfie_pkg::OFF_STATUS, 32'h0000_0000);
    chk(rd[7:0] & m, v, what);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_io();
    chk_st(8'hFF, bfie_pkg::STATUS_RESET, "status reset");
    apb(1'h0, 8'h40, 32'h0000_0000);
    chk(err, 1'h1, "unmapped error");
    wr(bfie_pkg::OFF_STATUS, 32'h0000_00AA);
    wr(bfie_pkg::OFF_IOREG, 32'h0000_0000);
    exec(4'h1, 3'h5, 2'h0);
    chk(nbusy, 2, "set cycles");
    apb(1'h0, bfie_pkg::OFF_IOREG, 32'h0000_0000);
    chk(rd[7:0], 8'h20, "io set");
    chk_st(8'hFF, 8'hAA, "set flags");
    wr(bfie_pkg::OFF_IOREG, 32'h0000_00FF);
    exec(4'h2, 3'h7, 2'h0);
    chk(nbusy, 2, "clear cycles");
    apb(1'h0, bfie_pkg::OFF_IOREG, 32'h0000_0000);
    chk(rd[7:0], 8'h7F, "io clear");
    chk_st(8'hFF, 8'hAA, "clear flags");
    $display("io bit test finished");
  endtask

  task automatic t_rot();
    wr(bfie_pkg::OFF_STATUS, 32'h0000_00E1);
    setreg(2'h1, 8'h81);
    exec(4'h3, 3'h0, 2'h1);
    chk(nbusy, 1, "rotate left cycles");
    chk_reg(2'h1, 8'h03, "rotate left value");
    chk_st(8'hEF, 8'hE9, "rotate left flags");
    wr(bfie_pkg::OFF_STATUS, 32'h0000_00E0);
    setreg(2'h2, 8'h01);
    exec(4'h4, 3'h0, 2'h2);
    chk(nbusy, 1, "rotate right cycles");
    chk_reg(2'h2, 8'h00, "rotate right value");
    chk_st(8'hEF, 8'hEB, "rotate right flags");
    $display("rotate test finished");
  endtask

  task automatic t_bit();
    wr(bfie_pkg::OFF_STATUS, 32'h0000_0000);
    setreg(2'h2, 8'h10);
    exec(4'h5, 3'h4, 2'h2);
    chk(nbusy, 1, "to T cycles");
    chk_st(8'hFF, 8'h40, "T set");
    wr(bfie_pkg::OFF_STATUS, 32'h0000_00FF);
    exec(4'h5, 3'h0, 2'h2);
    chk_st(8'hFF, 8'hBF, "T cleared");
    wr(bfie_pkg::OFF_STATUS, 32'h0000_0040);
    setreg(2'h3, 8'h00);
    exec(4'h6, 3'h7, 2'h3);
    chk(nbusy, 1, "from T cycles");
    chk_reg(2'h3, 8'h80, "T to bit");
    chk_st(8'hFF, 8'h40, "from T flags");
    $display("transfer bit test finished");
  endtask

  task automatic t_flags();
    logic [7:0] m;
    for (int i = 0; i < 6; i++) begin
      m = 8'h01 << ((i < 2) ? bfie_pkg::FLAG_V : (i < 4) ? bfie_pkg::FLAG_H : bfie_pkg::FLAG_S);
      wr(bfie_pkg::OFF_STATUS, (i % 2 == 0) ? 32'h0000_0000 : 32'h0000_00FF);
      exec(4'(7 + i), 3'h0, 2'h0);
      chk(nbusy, 1, "flag cycles");
      chk_st(8'hFF, (i % 2 == 0) ? m : ~m, "flag op");
    end
    $display("flag test finished");
  endtask

  task automatic t_sys();
    wr(bfie_pkg::OFF_STATUS, 32'h0000_005A);
    exec(4'hD, 3'h0, 2'h0);
    chk(nbusy, 1, "sleep cycles");
    chk(sleep_req, 1'h1, "sleep request");
    apb(1'h0, bfie_pkg::OFF_STATE, 32'h0000_0000);
    chk(rd, 32'h0000_0002, "state sleeping");
    chk_st(8'hFF, 8'h5A, "sleep flags");
    wake <= 1'h1;
    @(posedge clock_i);
    wake <= 1'h0;
    repeat (2) @(posedge clock_i);
    chk(sleep_req, 1'h0, "wake clears");
    exec(4'hE, 3'h0, 2'h0);
    chk(nbusy, 1, "restart cycles");
    chk(npulse, 1, "restart pulse");
    chk_st(8'hFF, 8'h5A, "restart flags");
    apb(1'h0, bfie_pkg::OFF_EVENTS, 32'h0000_0000);
    chk(rd, 32'h0001_0001, "event counts");
    $display("sleep and watchdog test finished");
  endtask

  task automatic t_ptr();
    wr(bfie_pkg::OFF_STATUS, 32'h0000_0033);
    wr(bfie_pkg::OFF_PTR, 32'h0000_0003);
    setreg(2'h0, 8'h5A);
    setreg(2'h1, 8'h00);
    exec(4'hF, 3'h1, 2'h0);
    chk(nbusy, 2, "store cycles");
    exec(4'hF, 3'h0, 2'h1);
    chk(nbusy, 2, "load cycles");
    chk_reg(2'h1, 8'h5A, "load value");
    chk_st(8'hFF, 8'h33, "pointer flags");
    apb(1'h0, bfie_pkg::OFF_PTR, 32'h0000_0000);
    chk(rd, 32'h0000_0003, "pointer readback");
    $display("pointer test finished");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'h0;
    t_io();
    t_rot();
    t_bit();
    t_flags();
    t_sys();
    t_ptr();
    conclude();
  end
endmodule
